// *** core_flags_pkg.sv ***
// How it works
// - flag-updating ops never data-write flag bits
// - clear of flag register only sets zero
// - upper three flag bits read zero
// - negative flag copies result msb
// - overflow flag on signed sign change
// - zero flag when result is zero
// - add/sub digit carry from bit three
// - add/sub carry from result msb
// - subtract adds complement, carries mean no-borrow
// - rotate loads digit carry from bit 4/3
// - rotate loads carry with shifted-out bit
// - jump carries 20-bit literal target
// - file address from opcode low byte
// - bank or access bank forms 12-bit address
// - file-to-file move ignores bank select
// - destination bit picks file or working
// - three 12-bit pointer pairs
// - virtual operand accesses pointed location
// - indirect ignores bank and access bit
// - post increment, post decrement and pre increment pointer
// - offset operand changes neither pointer nor working
// - pointer steps carry across whole pair
// - pointer steps leave flags alone
`default_nettype none
package core_flags_pkg;
   localparam logic [11:0] FLAGS_ADDR = 12'hfe8;
   localparam logic [11:0] BANK_ADDR = 12'hfe9;
   localparam logic [11:0] WORK_ADDR = 12'hfea;
   localparam logic [11:0] IND_BASE = 12'hfc0;
   localparam logic [2:0] SUB_PLAIN = 3'h0;
   localparam logic [2:0] SUB_POST_INCREMENT_OPERAND = 3'h1;
   localparam logic [2:0] SUB_POST_DECREMENT_OPERAND = 3'h2;
   localparam logic [2:0] SUB_PRE_INCREMENT_OPERAND = 3'h3;
   localparam logic [2:0] SUB_OFFSET_BY_WORKING_OPERAND = 3'h4;
   localparam logic [2:0] SUB_PTR_LO = 3'h5;
   localparam logic [2:0] SUB_PTR_HI = 3'h6;
   localparam logic [7:0] ACCESS_SPLIT = 8'h80;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
   localparam int FLAG_N = 4;
   localparam int FLAG_OV = 3;
   localparam int FLAG_Z = 2;
   localparam int FLAG_DC = 1;
   localparam int FLAG_C = 0;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [11:0] APB_FLAGS = 12'h000;
   localparam logic [11:0] APB_BANK = 12'h004;
   localparam logic [11:0] APB_WORK = 12'h008;
   localparam logic [11:0] APB_PTR0 = 12'h00c;
   localparam logic [11:0] APB_STATE = 12'h01c;
   typedef enum logic [3:0] {
      OP_ADD = 4'h0, OP_SUB = 4'h1, OP_AND = 4'h2, OP_IOR = 4'h3, OP_XOR = 4'h4,
      OP_MOVF = 4'h5, OP_CLR = 4'h6, OP_MOVE_WORKING_TO_FILE = 4'h7, OP_RRF = 4'h8, OP_RLF = 4'h9,
      OP_BCF = 4'ha, OP_BSF = 4'hb, OP_SWAP = 4'hc, OP_FILE_TO_FILE_MOVE = 4'hd, OP_JUMP = 4'he
   } op_t;
   typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_RD = 3'b010, ST_WB = 3'b100} state_t;
   typedef struct packed {
      op_t op;
      logic [7:0] f;
      logic acc_sel;
      logic dst_sel;
      logic [2:0] bit_no;
      logic [11:0] src;
      logic [11:0] dst;
      logic [19:0] target;
   } ins_t;
   typedef struct packed {
      logic [11:0] addr;
      logic we;
      logic [7:0] wdata;
   } mem_req_t;
endpackage
`default_nettype wire

// *** core_flags_addr.sv ***
`default_nettype none
module core_flags_addr import core_flags_pkg::*; #(
   parameter int PTR_COUNT = 3
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ins_valid,
   input wire ins_t ins,
   output logic ins_ready,
   input wire logic [7:0] mem_rdata,
   output mem_req_t mem_req,
   output logic jump_valid,
   output logic [19:0] jump_addr
);
   if (PTR_COUNT < 1 || PTR_COUNT > 4) begin : g_bad_count
      $error("PTR_COUNT must be 1 to 4");
   end

   // ----------------------------------------
   // decoding helpers
   // ----------------------------------------
   function automatic logic in_group(input logic [11:0] x);
      return x[11:5] == IND_BASE[11:5] && int'(x[4:3]) < PTR_COUNT;
   endfunction

   function automatic logic virt_hit(input logic [11:0] x);
      return in_group(x) && x[2:0] <= SUB_OFFSET_BY_WORKING_OPERAND;
   endfunction

   function automatic logic internal(input logic [11:0] x);
      return x == FLAGS_ADDR || x == BANK_ADDR || x == WORK_ADDR ||
         (in_group(x) && (x[2:0] == SUB_PTR_LO || x[2:0] == SUB_PTR_HI));
   endfunction

   function automatic logic [11:0] direct_addr(input logic [7:0] f, input logic a, input logic [3:0] bank);
      if (a) begin
         return {bank, f};
      end
      return {(f >= ACCESS_SPLIT) ? ACCESS_HI_BANK : 4'h0, f};
   endfunction

   state_t state_r;
   state_t state_nxt;
   logic [7:0] flags_r;
   logic [7:0] w_r;
   logic [3:0] bsr_r;
   logic [11:0] ptr_r [PTR_COUNT];
   ins_t ins_r;
   logic [11:0] opnd_r;
   logic null_r;
   logic [11:0] last_r;
   logic ready_r;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   mem_req_t mem_r;
   logic jump_r;
   logic [19:0] jaddr_r;

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign ins_ready = ready_r;
   assign mem_req = mem_r;
   assign jump_valid = jump_r;
   assign jump_addr = jaddr_r;

   // ----------------------------------------
   // issue and address generation
   // ----------------------------------------
   logic acc;
   logic [11:0] raw;
   logic [1:0] idx;
   logic [2:0] sub;
   logic vhit;
   logic [11:0] base;
   logic [11:0] eff;
   logic [11:0] ptr_new;

   assign acc = ins_valid && ready_r;
   assign raw = (ins.op == OP_FILE_TO_FILE_MOVE) ? ins.src : direct_addr(ins.f, ins.acc_sel, bsr_r);
   assign idx = raw[4:3];
   assign sub = raw[2:0];
   assign vhit = ins.op != OP_JUMP && virt_hit(raw);
   assign base = (int'(idx) < PTR_COUNT) ? ptr_r[idx] : 12'h000;

   always_comb begin
      eff = raw;
      ptr_new = base;
      if (vhit) begin
         // full 12-bit pointer, bank and access bit play no part
         case (sub)
            SUB_POST_INCREMENT_OPERAND: begin
               eff = base;
               ptr_new = base + 12'h001;
            end
            SUB_POST_DECREMENT_OPERAND: begin
               eff = base;
               ptr_new = base - 12'h001;
            end
            SUB_PRE_INCREMENT_OPERAND: begin
               ptr_new = base + 12'h001;
               eff = ptr_new;
            end
            SUB_OFFSET_BY_WORKING_OPERAND: begin
               eff = base + {{4{w_r[7]}}, w_r};
            end
            default: begin
               eff = base;
            end
         endcase
      end
   end

   // ----------------------------------------
   // operand fetch and alu
   // ----------------------------------------
   logic in_rd;
   logic [7:0] int_val;
   logic [7:0] opnd;
   logic [7:0] bop;
   logic cin;
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] res;
   logic [4:0] upd;
   logic c_calc;
   logic dc_calc;
   logic ov_calc;
   logic [4:0] flags_alu;
   logic has_d;
   logic to_w;
   logic [11:0] wtgt;
   logic wr_file;
   logic core_int;
   logic mem_wr;

   assign in_rd = state_r == ST_RD;

   always_comb begin
      int_val = 8'h00;
      if (opnd_r == FLAGS_ADDR) begin
         int_val = {3'b000, flags_r[4:0]};
      end else if (opnd_r == BANK_ADDR) begin
         int_val = {4'h0, bsr_r};
      end else if (opnd_r == WORK_ADDR) begin
         int_val = w_r;
      end else if (in_group(opnd_r)) begin
         int_val = (opnd_r[2:0] == SUB_PTR_LO) ? ptr_r[opnd_r[4:3]][7:0] : {4'h0, ptr_r[opnd_r[4:3]][11:8]};
      end
   end

   assign opnd = null_r ? 8'h00 : (internal(opnd_r) ? int_val : mem_rdata);
   assign bop = (ins_r.op == OP_SUB) ? ~w_r : w_r;
   assign cin = ins_r.op == OP_SUB;
   assign sum = {1'b0, opnd} + {1'b0, bop} + {8'h00, cin};
   assign nib = {1'b0, opnd[3:0]} + {1'b0, bop[3:0]} + {4'h0, cin};

   always_comb begin
      res = opnd;
      upd = 5'b00000;
      c_calc = sum[8];
      dc_calc = nib[4];
      ov_calc = (opnd[7] == bop[7]) && (sum[7] != opnd[7]);
      case (ins_r.op)
         OP_ADD, OP_SUB: begin
            res = sum[7:0];
            upd = 5'b11111;
         end
         OP_AND: begin
            res = opnd & w_r;
            upd = 5'b10100;
         end
         OP_IOR: begin
            res = opnd | w_r;
            upd = 5'b10100;
         end
         OP_XOR: begin
            res = opnd ^ w_r;
            upd = 5'b10100;
         end
         OP_MOVF: begin
            upd = 5'b10100;
         end
         OP_CLR: begin
            res = 8'h00;
            upd = 5'b00100;
         end
         OP_MOVE_WORKING_TO_FILE: begin
            res = w_r;
         end
         OP_RRF: begin
            res = {opnd[0], opnd[7:1]};
            c_calc = opnd[0];
            dc_calc = opnd[4];
            upd = 5'b10111;
         end
         OP_RLF: begin
            res = {opnd[6:0], opnd[7]};
            c_calc = opnd[7];
            dc_calc = opnd[3];
            upd = 5'b10111;
         end
         OP_BCF: begin
            res = opnd & ~(8'h01 << ins_r.bit_no);
         end
         OP_BSF: begin
            res = opnd | (8'h01 << ins_r.bit_no);
         end
         OP_SWAP: begin
            res = {opnd[3:0], opnd[7:4]};
         end
         default: begin
            res = opnd;
         end
      endcase
   end

   // negative copies msb, zero on an all-zero result
   assign flags_alu = (flags_r[4:0] & ~upd) | ({res[7], ov_calc, res == 8'h00, dc_calc, c_calc} & upd);
   assign has_d = ins_r.op inside {OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_MOVF, OP_RRF, OP_RLF, OP_SWAP};
   assign to_w = has_d && !ins_r.dst_sel;
   assign wtgt = (ins_r.op == OP_FILE_TO_FILE_MOVE) ? ins_r.dst : opnd_r;
   assign wr_file = !to_w && !((ins_r.op == OP_FILE_TO_FILE_MOVE) ? virt_hit(ins_r.dst) : null_r);
   assign core_int = in_rd && wr_file && internal(wtgt);
   assign mem_wr = in_rd && wr_file && !internal(wtgt);

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   logic apb_go;
   logic apb_wr;
   logic apb_map;
   logic [31:0] apb_rd;

   assign apb_go = psel && penable && !pready_r && state_r == ST_IDLE && !acc;
   assign apb_wr = psel && penable && pready_r && pwrite && apb_map;

   always_comb begin
      apb_map = 1'b1;
      apb_rd = 32'h00000000;
      if (paddr == APB_FLAGS) begin
         apb_rd = {27'h0, flags_r[4:0]};
      end else if (paddr == APB_BANK) begin
         apb_rd = {28'h0, bsr_r};
      end else if (paddr == APB_WORK) begin
         apb_rd = {24'h0, w_r};
      end else if (paddr == APB_STATE) begin
         apb_rd = {17'h0, state_r, last_r};
      end else if (paddr[1:0] == 2'b00 && paddr >= APB_PTR0 && int'(paddr - APB_PTR0) < 4 * PTR_COUNT) begin
         apb_rd = {20'h0, ptr_r[paddr[3:2] - APB_PTR0[3:2]]};
      end else begin
         apb_map = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end else if (ce) begin
         pready_r <= apb_go;
         if (apb_go) begin
            pslverr_r <= !apb_map;
            prdata_r <= apb_rd;
         end
      end
   end

   // ----------------------------------------
   // sequencing
   // ----------------------------------------
   always_comb begin
      case (state_r)
         ST_IDLE: state_nxt = (acc && ins.op != OP_JUMP) ? ST_RD : ST_IDLE;
         ST_RD: state_nxt = mem_wr ? ST_WB : ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= ST_IDLE;
         ready_r <= 1'b0;
      end else if (ce) begin
         state_r <= state_nxt;
         ready_r <= state_nxt == ST_IDLE && !apb_go;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ins_r <= '0;
         opnd_r <= 12'h000;
         null_r <= 1'b0;
         last_r <= 12'h000;
      end else if (ce && acc) begin
         ins_r <= ins;
         opnd_r <= eff;
         null_r <= vhit && virt_hit(eff);
         last_r <= eff;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         jump_r <= 1'b0;
         jaddr_r <= 20'h00000;
      end else if (ce) begin
         jump_r <= acc && ins.op == OP_JUMP;
         if (acc && ins.op == OP_JUMP) begin
            jaddr_r <= ins.target;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mem_r <= '0;
      end else if (ce) begin
         if (acc) begin
            mem_r <= '{addr: eff, we: 1'b0, wdata: 8'h00};
         end else if (mem_wr) begin
            mem_r <= '{addr: wtgt, we: 1'b1, wdata: res};
         end else begin
            mem_r.we <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // core registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         flags_r <= FLAGS_RST;
      end else if (ce) begin
         if (in_rd) begin
            if (core_int && wtgt == FLAGS_ADDR && upd == 5'b00000) begin
               flags_r <= {3'b000, res[4:0]};
            end else begin
               flags_r <= {3'b000, flags_alu};
            end
         end else if (apb_wr && paddr == APB_FLAGS) begin
            flags_r <= {3'b000, pwdata[4:0]};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         w_r <= 8'h00;
      end else if (ce) begin
         if (in_rd && (to_w || (core_int && wtgt == WORK_ADDR))) begin
            w_r <= res;
         end else if (apb_wr && paddr == APB_WORK) begin
            w_r <= pwdata[7:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         bsr_r <= 4'h0;
      end else if (ce) begin
         if (core_int && wtgt == BANK_ADDR) begin
            bsr_r <= res[3:0];
         end else if (apb_wr && paddr == APB_BANK) begin
            bsr_r <= pwdata[3:0];
         end
      end
   end

   for (genvar i = 0; i < PTR_COUNT; i++) begin : g_ptr
      always_ff @(posedge clk) begin
         if (rst) begin
            ptr_r[i] <= 12'h000;
         end else if (ce) begin
            if (acc && vhit && int'(idx) == i) begin
               ptr_r[i] <= ptr_new;
            end else if (core_int && in_group(wtgt) && int'(wtgt[4:3]) == i) begin
               if (wtgt[2:0] == SUB_PTR_LO) begin
                  ptr_r[i][7:0] <= res;
               end else begin
                  ptr_r[i][11:8] <= res[3:0];
               end
            end else if (apb_wr && paddr == APB_PTR0 + 12'(4 * i)) begin
               ptr_r[i] <= pwdata[11:0];
            end
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic add_c_ref;
   logic sub_c_ref;
   logic dc_ref;
   assign add_c_ref = ({1'b0, opnd} + {1'b0, w_r}) > 9'h0ff;
   assign sub_c_ref = opnd >= w_r;
   assign dc_ref = ({1'b0, opnd[3:0]} + {1'b0, w_r[3:0]}) > 5'h0f;

   default clocking cb @(posedge clk iff ce);
   endclocking
   default disable iff (rst);

   sequence s_issue_ind(logic [2:0] s);
      acc && vhit && sub == s;
   endsequence

   sequence s_exec(op_t o);
      in_rd && ins_r.op == o;
   endsequence

   chk_flags_upper_zero: assert property (flags_r[7:5] == 3'b000)
      else $error("upper flag bits set");
   chk_clr_zero_only: assert property (s_exec(OP_CLR) ##0 (core_int && wtgt == FLAGS_ADDR) |=>
      flags_r[4:0] == {$past(flags_r[4:3]), 1'b1, $past(flags_r[1:0])})
      else $error("clear of flags wrong");
   chk_add_flags_kept: assert property (s_exec(OP_ADD) ##0 (core_int && wtgt == FLAGS_ADDR) |=>
      flags_r[FLAG_C] == $past(add_c_ref) && flags_r[FLAG_DC] == $past(dc_ref))
      else $error("flag write not suppressed");
   chk_neg_msb: assert property (in_rd && upd[4] |=> flags_r[FLAG_N] == $past(res[7]))
      else $error("negative flag wrong");
   chk_add_carry: assert property (s_exec(OP_ADD) |=> flags_r[FLAG_C] == $past(add_c_ref))
      else $error("add carry wrong");
   chk_sub_borrow: assert property (s_exec(OP_SUB) |=> flags_r[FLAG_C] == $past(sub_c_ref))
      else $error("subtract borrow wrong");
   chk_rotate_carry: assert property (s_exec(OP_RLF) |=> flags_r[FLAG_C] == $past(opnd[7]))
      else $error("rotate carry wrong");
   chk_post_increment_operand_step: assert property (s_issue_ind(SUB_POST_INCREMENT_OPERAND) |=>
      mem_req.addr == $past(base) && ptr_r[$past(idx)] == $past(base) + 12'h001)
      else $error("post increment wrong");
   chk_offset_by_working_operand_stable: assert property (s_issue_ind(SUB_OFFSET_BY_WORKING_OPERAND) |=>
      ptr_r[$past(idx)] == $past(base) && $stable(w_r))
      else $error("offset operand changed state");
   chk_ptr_no_flags: assert property (acc |=> $stable(flags_r))
      else $error("issue changed flags");
   chk_bank_direct: assert property (acc && !vhit && ins.acc_sel && ins.op != OP_FILE_TO_FILE_MOVE && ins.op != OP_JUMP |=>
      mem_req.addr == {$past(bsr_r), $past(ins.f)})
      else $error("banked address wrong");
   chk_jump_target: assert property (acc && ins.op == OP_JUMP |=> jump_valid && jump_addr == $past(ins.target))
      else $error("jump target wrong");
   chk_dest_work: assert property (in_rd && to_w |=> w_r == $past(res) && !mem_req.we)
      else $error("working destination wrong");
endmodule
`default_nettype wire

// *** testbench.sv ***
`default_nettype none
module testbench import core_flags_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // signals and design
   // ------------------------------------------------------------
   logic clk, rst, ce, psel, penable, pwrite, ins_valid, err, we2, jv1, jv2;
   logic [11:0] paddr, a1, a2;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, ins_ready, jump_valid;
   logic [19:0] jump_addr;
   logic [7:0] mem_rdata, wd2;
   ins_t ins;
   mem_req_t mem_req;
   logic [7:0] mem [0:4095];
   int fail_count, checks_done;
   core_flags_addr #(.PTR_COUNT(3)) i_core_flags_addr (
      .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ins_valid(ins_valid),
      .ins(ins), .ins_ready(ins_ready), .mem_rdata(mem_rdata), .mem_req(mem_req),
      .jump_valid(jump_valid), .jump_addr(jump_addr)
   );
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // data memory answers in the cycle after issue
   assign mem_rdata = mem[mem_req.addr];
   always @(posedge clk) begin
      if (mem_req.we === 1'b1) mem[mem_req.addr] <= mem_req.wdata;
   end
   // ------------------------------------------------------------
   // tasks and expectations
   // ------------------------------------------------------------
   task results;
      $display("comparisons %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask
   task tmo;
      fail_count++;
      $display("Error handshake expected answer seen none");
      results();
   endtask
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         n++;
         if (n > 50) tmo();
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rdchk(input string nm, input logic [11:0] ad, input logic [31:0] e);
      apb(1'b0, ad, 32'h0);
      chk(nm, e, rd);
   endtask
   task run(input ins_t i);
      int n;
      n = 0;
      @(posedge clk);
      ins <= i;
      ins_valid <= 1'b1;
      @(posedge clk);
      while (ins_ready !== 1'b1) begin
         n++;
         if (n > 50) tmo();
         @(posedge clk);
      end
      ins_valid <= 1'b0;
      @(posedge clk);
      a1 = mem_req.addr;
      jv1 = jump_valid;
      @(posedge clk);
      a2 = mem_req.addr;
      we2 = mem_req.we;
      wd2 = mem_req.wdata;
      jv2 = jump_valid;
   endtask
   function automatic ins_t mk(input op_t op, input logic [7:0] f, input logic a, input logic d);
      ins_t i;
      i = '0;
      i.op = op;
      i.f = f;
      i.acc_sel = a;
      i.dst_sel = d;
      return i;
   endfunction
   // {flags, result}; subtract is f plus complement of w plus one
   function automatic logic [15:0] alu(input logic [7:0] a, input logic [7:0] b, input logic s);
      logic [7:0] c;
      logic [8:0] t;
      logic [4:0] h;
      c = s ? ~b : b;
      t = {1'b0, a} + {1'b0, c} + 9'(s);
      h = {1'b0, a[3:0]} + {1'b0, c[3:0]} + 5'(s);
      return {3'h0, t[7], (a[7] == c[7]) && (t[7] != a[7]), t[7:0] == 8'h00, h[4], t[8], t[7:0]};
   endfunction
   // {flags, result} of and, or, xor, swap, bit clear, starting from flags 0b
   function automatic logic [15:0] lgc(input int o, input logic [7:0] a, input logic [7:0] b, input logic [2:0] n);
      logic [7:0] t;
      t = (o == 0) ? a & b : (o == 1) ? a | b : (o == 2) ? a ^ b : (o == 3) ? {a[3:0], a[7:4]} : a & ~(8'h01 << n);
      return (o < 3) ? {3'h0, t[7], 1'b1, t == 8'h00, 2'b11, t} : {8'h0b, t};
   endfunction
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      ins_t i;
      logic [7:0] a, b, f, r;
      logic [3:0] bk;
      logic [15:0] e;
      logic [11:0] ea, ep;
      logic [7:0] ca [4];
      op_t lo [5];
      int k, n, s;
      ca = '{8'h7f, 8'h80, 8'h0f, 8'h01};
      lo = '{OP_AND, OP_IOR, OP_XOR, OP_SWAP, OP_BCF};
      rst = 1'b1;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      ins_valid = 1'b0;
      ins = '0;
      fail_count = 0;
      checks_done = 0;
      for (k = 0; k < 4096; k++) mem[k] = 8'(k) ^ 8'h5a;
      void'($urandom(32'h97c7));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rdchk("flags reset", APB_FLAGS, 32'h0);
      apb(1'b1, APB_FLAGS, 32'hffff_ffff);
      rdchk("flags upper", APB_FLAGS, 32'h1f);
      apb(1'b0, 12'h020, 32'h0);
      chk("unmapped error", 32'h1, 32'(err));
      for (k = 0; k < 3; k++) begin
         apb(1'b1, APB_PTR0 + 12'(4 * k), 32'hffff_f000 | 32'(12'h9a5 + 12'(k)));
         rdchk("pointer width", APB_PTR0 + 12'(4 * k), 32'(12'h9a5 + 12'(k)));
      end
      // add and subtract, corners first, alternate destinations
      for (k = 0; k < 24; k++) begin
         a = (k < 4) ? ca[k] : 8'($urandom);
         b = (k < 4) ? 8'h01 : 8'($urandom);
         bk = 4'($urandom % 15);
         f = 8'($urandom);
         apb(1'b1, APB_BANK, 32'(bk));
         apb(1'b1, APB_WORK, 32'(b));
         mem[{bk, f}] = a;
         e = alu(a, b, k[0]);
         run(mk(k[0] ? OP_SUB : OP_ADD, f, 1'b1, k[1]));
         chk("banked addr", 32'({bk, f}), 32'(a1));
         if (k[1]) begin
            chk("file write", 32'({1'b1, bk, f, e[7:0]}), 32'({we2, a2, wd2}));
         end else begin
            rdchk("working result", APB_WORK, 32'(e[7:0]));
         end
         rdchk("arith flags", APB_FLAGS, 32'(e[15:8]));
      end
      run(mk(OP_MOVF, 8'h40, 1'b0, 1'b0));
      chk("access low", 32'h040, 32'(a1));
      run(mk(OP_MOVF, 8'h90, 1'b0, 1'b0));
      chk("access high", 32'hf90, 32'(a1));
      // flag register as destination
      apb(1'b1, APB_FLAGS, 32'h0);
      apb(1'b1, APB_WORK, 32'h1);
      run(mk(OP_ADD, FLAGS_ADDR[7:0], 1'b0, 1'b1));
      chk("flags no mem write", 32'h0, 32'(we2));
      rdchk("flags dest", APB_FLAGS, 32'h0);
      apb(1'b1, APB_FLAGS, 32'h13);
      run(mk(OP_CLR, FLAGS_ADDR[7:0], 1'b0, 1'b1));
      rdchk("clear flags", APB_FLAGS, 32'h17);
      apb(1'b1, APB_WORK, 32'h0a);
      run(mk(OP_MOVE_WORKING_TO_FILE, FLAGS_ADDR[7:0], 1'b0, 1'b1));
      rdchk("move to flags", APB_FLAGS, 32'h0a);
      // rotates
      apb(1'b1, APB_BANK, 32'h2);
      for (k = 0; k < 8; k++) begin
         a = 8'($urandom);
         f = 8'($urandom);
         mem[{4'h2, f}] = a;
         run(mk(k[0] ? OP_RLF : OP_RRF, f, 1'b1, 1'b0));
         apb(1'b0, APB_FLAGS, 32'h0);
         chk("rotate carries", 32'(k[0] ? {a[3], a[7]} : {a[4], a[0]}), 32'(rd[1:0]));
      end
      // logic ops, swap and bit clear into the file, zero operand first
      for (k = 0; k < 10; k++) begin
         a = (k < 5) ? 8'h00 : 8'($urandom);
         b = 8'($urandom);
         f = 8'($urandom);
         mem[{4'h2, f}] = a;
         apb(1'b1, APB_WORK, 32'(b));
         apb(1'b1, APB_FLAGS, 32'h0b);
         i = mk(lo[k % 5], f, 1'b1, 1'b1);
         i.bit_no = 3'(k);
         e = lgc(k % 5, a, b, 3'(k));
         run(i);
         chk("logic result", 32'({1'b1, 4'h2, f, e[7:0]}), 32'({we2, a2, wd2}));
         rdchk("logic flags", APB_FLAGS, 32'(e[15:8]));
      end
      // indirect operands of every pointer, bank left nonzero
      apb(1'b1, APB_BANK, 32'h5);
      for (k = 0; k < 15; k++) begin
         n = k / 5;
         s = k % 5;
         ea = (s == 3) ? 12'h100 : (s == 4) ? 12'h0fd : 12'h0ff;
         ep = (s == 1 || s == 3) ? 12'h100 : (s == 2) ? 12'h0fe : 12'h0ff;
         apb(1'b1, APB_PTR0 + 12'(4 * n), 32'h0ff);
         apb(1'b1, APB_WORK, 32'hfe);
         apb(1'b1, APB_FLAGS, 32'h15);
         r = mem[ea] | 8'h40;
         i = mk(OP_BSF, IND_BASE[7:0] + 8'(8 * n + s), 1'b0, 1'b1);
         i.bit_no = 3'h6;
         run(i);
         chk("indirect addr", 32'(ea), 32'(a1));
         chk("indirect write", 32'({1'b1, ea, r}), 32'({we2, a2, wd2}));
         rdchk("pointer step", APB_PTR0 + 12'(4 * n), 32'(ep));
         rdchk("pointer flags", APB_FLAGS, 32'h15);
         rdchk("offset w kept", APB_WORK, 32'hfe);
      end
      // file to file move with bank set, then a jump
      apb(1'b1, APB_BANK, 32'h3);
      i = mk(OP_FILE_TO_FILE_MOVE, 8'h00, 1'b1, 1'b0);
      i.src = 12'h123;
      i.dst = 12'h234;
      r = mem[12'h123];
      run(i);
      chk("move source", 32'h123, 32'(a1));
      chk("move dest", 32'({1'b1, 12'h234, r}), 32'({we2, a2, wd2}));
      i = mk(OP_JUMP, 8'h00, 1'b0, 1'b0);
      i.target = 20'($urandom);
      run(i);
      chk("jump pulse", 32'h2, 32'({jv1, jv2}));
      chk("jump target", 32'(i.target), 32'(jump_addr));
      results();
   end
endmodule
`default_nettype wire
